// >>> shared/fram_spi_pkg.sv
// Behaviour
// R1: Read command then three address bytes, 17-bit start.
// R2: Data bytes shift out; serial input ignored.
// R3: Address advances per byte, wraps to zero.
// R4: Data bytes leave most significant bit first.
// R5: Select rising ends read, output floats.
// R6: Fast read: code, three address bytes, dummy.
// R7: Fast read waits eight dummy clocks, else normal.
// R8: Pause low with clock low suspends; high resumes.
// R9: While paused, clock and select toggles ignored.
// R10: Sleep code then select rising enters sleep.
// R11: Asleep: ignore clock and input, output floats.
// R12: Select falling wakes; output floats during recovery.
// R13: Master may send dummy read, then wait.
// R14: Identity command returns nine bytes, maker first.
// R15: Maker part: six continuation bytes, maker byte.
// R16: Product bytes: family, density, sub, revision, reserved.
// R17: Serial number command returns eight bytes.
// R18: Serial number: customer, unique value, CRC, high first.
// R19: Unassigned customer identifier reads as zero.
// R20: Master checks CRC over first seven bytes.
// R21: CRC-8 table lookup, start zero, polynomial 0x07.
// R22: Normal read command code is 03h.
// R23: Sample on rising, change on falling; both idles.
package fram_spi_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Command codes
   localparam logic [7:0] CMD_READ = 8'h03;
   localparam logic [7:0] CMD_FAST_READ = 8'h0b;
   localparam logic [7:0] CMD_SLEEP = 8'hb9;
   localparam logic [7:0] CMD_READ_IDENTITY = 8'h9f;
   localparam logic [7:0] CMD_SERIAL_NUMBER = 8'hc3;

   ////////////////////////////////////////////////////////////////////////////
   // Geometry and field positions
   localparam int ADDR_W = 17;
   localparam logic [3:0] ID_BYTES = 4'h9;
   localparam logic [3:0] SN_BYTES = 4'h8;
   localparam logic [1:0] ADDR_BYTES_LAST = 2'h2;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'h00;
   localparam logic [15:0] CUSTOMER_ID_NONE = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
   localparam logic [7:0] BYTE_RST = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int WAKE_RECOVERY_TIME_NS = 400;
   localparam logic [7:0] WAKE_CYCLES =
      8'((WAKE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef struct packed {
      logic select_n;
      logic sclk;
      logic serial_in;
      logic pause_n;
   } spi_pins_t;

   typedef struct packed {
      logic data;
      logic oe;
   } spi_out_t;

   typedef enum logic [1:0] {
      SRC_MEM,
      SRC_ID,
      SRC_SN
   } src_t;

endpackage

// >>> design/pin_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser with edge detection on the settled level
module pin_sync (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic pin_i,
   input wire logic rst_level_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic meta_q;
   logic sync_q;
   logic prev_q;

   // First stage is read only by the second stage; stages hold the pin
   // relative to its idle level, so leaving reset makes no false edge
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= pin_i ^ rst_level_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Edges come from settled stages only, back in pin polarity
   assign level_o = sync_q ^ rst_level_i;
   assign rise_o = (sync_q ^ prev_q) & level_o;
   assign fall_o = (sync_q ^ prev_q) & ~level_o;
endmodule

// >>> design/crc8_calc.sv
`timescale 1ns/1ps
// CRC-8 over seven serial-number bytes, highest byte first
module crc8_calc
   import fram_spi_pkg::*;
(
   input wire logic [55:0] data_i,
   output logic [7:0] crc_o
);
   // Table entry for one index, same as the lookup table built from the polynomial
   function automatic logic [7:0] table_entry(input logic [7:0] idx);
      logic [7:0] c;
      c = idx;
      for (int b = 0; b < 8; b++) begin
         c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction

   // R21: lookup per byte
   always_comb begin
      crc_o = CRC_INIT;
      for (int i = 6; i >= 0; i--) begin
         crc_o = table_entry(crc_o ^ data_i[i*8 +: 8]);
      end
   end
endmodule

// >>> design/spi_fram_read_sleep_id.sv
`timescale 1ns/1ps
// Serial slave: read, fast read, pause, sleep, identity and serial number
module spi_fram_read_sleep_id #(
   parameter logic [7:0] CONT_BYTE = 8'h5a,      // Arbitrary value
   parameter logic [7:0] MAKER_BYTE = 8'h3c,     // Arbitrary value
   parameter logic [2:0] FAMILY = 3'h1,          // Arbitrary value
   parameter logic [4:0] DENSITY = 5'h04,        // Arbitrary value
   parameter logic [1:0] SUB_CODE = 2'h0,        // Arbitrary value
   parameter logic [2:0] REVISION = 3'h0,        // Arbitrary value
   parameter logic [15:0] CUSTOMER_ID = 16'h0000,
   parameter logic [39:0] UNIQUE_VALUE = 40'h0123456789 // Arbitrary value
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire fram_spi_pkg::spi_pins_t pins_i,
   input wire logic [7:0] mem_data_i,
   output logic [fram_spi_pkg::ADDR_W-1:0] mem_addr_o,
   output fram_spi_pkg::spi_out_t so_o,
   output logic asleep_o
);
   import fram_spi_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CMD,
      ST_ADDR,
      ST_DUMMY,
      ST_DATA,
      ST_IGNORE,
      ST_SLEEP,
      ST_WAKE
   } state_t;

   state_t state_q;
   src_t src_q;
   logic fast_q;
   logic sleep_arm_q;
   logic paused_q;
   logic [2:0] bit_cnt_q;
   logic [1:0] addr_cnt_q;
   logic [3:0] idx_q;
   logic [7:0] sh_in_q;
   logic [7:0] tx_q;
   logic [ADDR_W-1:0] addr_q;
   logic [7:0] wake_cnt_q;
   logic so_data_q;
   logic so_oe_q, drive_q;
   logic asleep_q;

   logic cs_lvl, cs_rise, cs_fall;
   logic sck_lvl, sck_rise, sck_fall;
   logic si_lvl;
   logic pause_lvl;
   logic rise_ok, fall_ok, byte_done;
   logic [7:0] byte_in;
   logic [7:0] crc;
   logic [71:0] id_word;
   logic [71:0] sn_word;
   logic [7:0] src_byte;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   pin_sync u_sync_cs (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(pins_i.select_n),
      .rst_level_i(1'b1),
      .level_o(cs_lvl),
      .rise_o(cs_rise),
      .fall_o(cs_fall)
   );
   pin_sync u_sync_sck (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(pins_i.sclk),
      .rst_level_i(1'b0),
      .level_o(sck_lvl),
      .rise_o(sck_rise),
      .fall_o(sck_fall)
   );
   pin_sync u_sync_si (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(pins_i.serial_in),
      .rst_level_i(1'b0),
      .level_o(si_lvl),
      .rise_o(),
      .fall_o()
   );
   pin_sync u_sync_pause (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(pins_i.pause_n),
      .rst_level_i(1'b1),
      .level_o(pause_lvl),
      .rise_o(),
      .fall_o()
   );

   ////////////////////////////////////////////////////////////////////////////
   // Identity and serial number words
   // R15: six continuation bytes then maker byte
   // R16: product fields, reserved bits zero
   assign id_word = {{6{CONT_BYTE}}, MAKER_BYTE, FAMILY, DENSITY, SUB_CODE, REVISION, 3'h0};

   crc8_calc u_crc (
      .data_i({CUSTOMER_ID, UNIQUE_VALUE}),
      .crc_o(crc)
   );

   // R18: customer, unique value, CRC, left-justified for byte picking
   // R19: customer id parameter defaults to zero
   assign sn_word = {CUSTOMER_ID, UNIQUE_VALUE, crc, BYTE_RST};

   // Byte i counted from the top of a 72-bit word
   function automatic logic [7:0] pick_byte(input logic [71:0] w, input logic [3:0] i);
      logic [71:0] s;
      s = w << {i, 3'b000};
      return s[71:64];
   endfunction

   // Byte source for the next outgoing data byte
   always_comb begin
      case (src_q)
         SRC_ID: src_byte = pick_byte(id_word, idx_q);
         SRC_SN: src_byte = pick_byte(sn_word, idx_q);
         default: src_byte = mem_data_i;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Edge qualification
   // R9: edges are masked while paused
   // R11: clock edges ignored outside an active frame
   assign rise_ok = sck_rise & ~paused_q & ~cs_lvl;
   assign fall_ok = sck_fall & ~paused_q & ~cs_lvl;
   assign byte_done = rise_ok & (bit_cnt_q == BIT_LAST);
   assign byte_in = {sh_in_q[6:0], si_lvl};

   ////////////////////////////////////////////////////////////////////////////
   // Pause tracking, only changes while the clock is low
   // R8: suspend and resume on pause level with clock low
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         paused_q <= 1'b0;
      end else if (!sck_lvl && state_q != ST_SLEEP && state_q != ST_WAKE) begin
         paused_q <= ~pause_lvl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bit counter and input shifter
   // R23: serial input sampled on rising clock edges
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bit_cnt_q <= 3'h0;
         sh_in_q <= BYTE_RST;
      end else if (cs_fall && !paused_q) begin
         bit_cnt_q <= 3'h0;
      end else if (rise_ok && state_q != ST_SLEEP && state_q != ST_WAKE) begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         sh_in_q <= byte_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transfer state machine
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= ST_IDLE;
         src_q <= SRC_MEM;
         fast_q <= 1'b0;
         sleep_arm_q <= 1'b0;
         addr_cnt_q <= 2'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (cs_fall) begin
                  state_q <= ST_CMD;
                  sleep_arm_q <= 1'b0;
               end
            end
            ST_SLEEP: begin
               // R12: select falling starts wake-up
               if (cs_fall) begin
                  state_q <= ST_WAKE;
               end
            end
            ST_WAKE: begin
               // Frame that caused wake-up is not honoured
               if (wake_cnt_q == 8'h00) begin
                  state_q <= cs_lvl ? ST_IDLE : ST_IGNORE;
               end
            end
            default: begin
               if (cs_rise && !paused_q) begin
                  // R5: select rising ends any transfer
                  // R10: armed sleep taken on select rising
                  state_q <= sleep_arm_q ? ST_SLEEP : ST_IDLE;
                  sleep_arm_q <= 1'b0;
               end else if (byte_done) begin
                  case (state_q)
                     ST_CMD: begin
                        addr_cnt_q <= 2'h0;
                        fast_q <= (byte_in == CMD_FAST_READ);
                        case (byte_in)
                           // R22: normal read code
                           // R6: fast read code
                           CMD_READ, CMD_FAST_READ: begin
                              state_q <= ST_ADDR;
                              src_q <= SRC_MEM;
                           end
                           // R14: identity readout
                           CMD_READ_IDENTITY: begin
                              state_q <= ST_DATA;
                              src_q <= SRC_ID;
                           end
                           // R17: serial number readout
                           CMD_SERIAL_NUMBER: begin
                              state_q <= ST_DATA;
                              src_q <= SRC_SN;
                           end
                           CMD_SLEEP: begin
                              state_q <= ST_IGNORE;
                              sleep_arm_q <= 1'b1;
                           end
                           default: state_q <= ST_IGNORE;
                        endcase
                     end
                     ST_ADDR: begin
                        addr_cnt_q <= addr_cnt_q + 2'h1;
                        if (addr_cnt_q == ADDR_BYTES_LAST) begin
                           // R7: dummy byte only for fast read
                           state_q <= fast_q ? ST_DUMMY : ST_DATA;
                        end
                     end
                     ST_DUMMY: state_q <= ST_DATA;
                     // A further whole byte after the sleep code cancels it
                     ST_IGNORE: sleep_arm_q <= 1'b0;
                     default: state_q <= state_q;
                  endcase
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address collection and sequential advance
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         addr_q <= ADDR_RST;
         idx_q <= 4'h0;
      end else if (byte_done && state_q == ST_CMD) begin
         idx_q <= 4'h0;
      end else if (byte_done && state_q == ST_ADDR) begin
         // R1: keep the low 17 bits of the address bytes
         addr_q <= ADDR_W'({addr_q, byte_in});
      end else if (byte_done && state_q == ST_DATA) begin
         // R3: natural 17-bit wrap from top to zero
         addr_q <= addr_q + ADDR_W'(1);
         if (src_q == SRC_ID) begin
            idx_q <= (idx_q == ID_BYTES - 4'h1) ? 4'h0 : idx_q + 4'h1;
         end else begin
            idx_q <= (idx_q == SN_BYTES - 4'h1) ? 4'h0 : idx_q + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output shifter
   // R2: data bytes driven, serial input never used here
   // R23: output changes after falling clock edges
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tx_q <= BYTE_RST;
         so_data_q <= 1'b0;
      end else if (fall_ok && state_q == ST_DATA) begin
         if (bit_cnt_q == 3'h0) begin
            // R4: most significant bit first
            so_data_q <= src_byte[7];
            tx_q <= {src_byte[6:0], 1'b0};
         end else begin
            so_data_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

   // Output enable; floats during pause so the bus can be shared
   // R11: floats while asleep
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         so_oe_q <= 1'b0;
         drive_q <= 1'b0;
      end else if (state_q != ST_DATA || (cs_lvl && !paused_q)) begin
         // R5: select high floats the output
         so_oe_q <= 1'b0;
         drive_q <= 1'b0;
      end else begin
         // R8: floats while paused, drives again on resume
         so_oe_q <= ~paused_q & (drive_q | (fall_ok & (bit_cnt_q == 3'h0)));
         drive_q <= drive_q | (fall_ok & (bit_cnt_q == 3'h0));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sleep and wake-up timing
   // R12: output stays off until recovery time ends
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wake_cnt_q <= 8'h00;
         asleep_q <= 1'b0;
      end else if (state_q == ST_SLEEP) begin
         wake_cnt_q <= WAKE_CYCLES - 8'h01;
         asleep_q <= 1'b1;
      end else if (state_q == ST_WAKE) begin
         wake_cnt_q <= wake_cnt_q - 8'h01;
         asleep_q <= 1'b1;
      end else begin
         asleep_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mem_addr_o <= ADDR_RST;
      end else begin
         mem_addr_o <= addr_q;
      end
   end

   assign so_o.data = so_data_q;
   assign so_o.oe = so_oe_q;
   assign asleep_o = asleep_q;
endmodule

// >>> verification/spi_checker.sv
`timescale 1ns/1ps
// Port-level watch on the serial slave
module spi_checker
   import fram_spi_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire fram_spi_pkg::spi_pins_t pins_i,
   input wire logic [7:0] mem_data_i,
   input wire logic [fram_spi_pkg::ADDR_W-1:0] mem_addr_o,
   input wire fram_spi_pkg::spi_out_t so_o,
   input wire logic asleep_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   // Six samples cover the synchroniser delay
   chk_deselect_float: assert property (pins_i.select_n [*6] |-> !so_o.oe)
      else $error("output driven while deselected");
   chk_sleep_float: assert property (asleep_o |-> !so_o.oe)
      else $error("output driven while asleep");
   chk_pause_float: assert property (!pins_i.pause_n [*5] |-> !so_o.oe)
      else $error("output driven while paused");
   chk_shift_on_fall: assert property (so_o.oe && $past(so_o.oe) && $changed(so_o.data) |-> !$past(pins_i.sclk, 2))
      else $error("data changed away from a falling clock");
   chk_drive_start: assert property ($rose(so_o.oe) |-> !pins_i.select_n && !$past(pins_i.sclk, 2))
      else $error("output enabled outside a low clock phase");
   chk_addr_step: assert property (so_o.oe && !pins_i.select_n && $changed(mem_addr_o)
      |-> mem_addr_o == 17'($past(mem_addr_o) + 17'h1))
      else $error("address did not step by one");
   chk_sleep_entry: assert property ($rose(asleep_o) |-> pins_i.select_n && $past(pins_i.select_n, 2))
      else $error("sleep entered without a select rise");
   // Recovery: still asleep for 8 cycles, but done within the window
   chk_wake_time: assert property (asleep_o && $fell(pins_i.select_n) |-> asleep_o [*8] ##[1:20] !asleep_o)
      else $error("wake recovery time wrong");

   // Main scenarios reached
   cover property ($rose(asleep_o));
   cover property ($rose(so_o.oe));
   cover property (!pins_i.pause_n && !pins_i.select_n);
endmodule

bind spi_fram_read_sleep_id spi_checker spi_checker_inst (
   .sys_clk_i(sys_clk_i),
   .sys_rst_i(sys_rst_i),
   .pins_i(pins_i),
   .mem_data_i(mem_data_i),
   .mem_addr_o(mem_addr_o),
   .so_o(so_o),
   .asleep_o(asleep_o)
);

// >>> verification/spi_host.sv
`timescale 1ns/1ps
// Bus master on the serial pins, clock idle low or high
module spi_host
   import fram_spi_pkg::*;
(
   input wire logic sys_clk_i,
   input wire fram_spi_pkg::spi_out_t so_i,
   output fram_spi_pkg::spi_pins_t pins_o
);
   logic idle_high;

   // Deselected, clock low, no pause
   initial begin
      idle_high = 1'b0;
      pins_o = '{select_n: 1'b1, sclk: 1'b0, serial_in: 1'b0, pause_n: 1'b1};
   end

   // Half of a 200 ns serial period
   task automatic half();
      repeat (4) @(posedge sys_clk_i);
   endtask

   // Clock settles at idle before select falls
   task automatic start();
      pins_o.sclk <= idle_high;
      half();
      pins_o.select_n <= 1'b0;
      half();
   endtask

   // data on fall, sample on rise
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         pins_o.sclk <= 1'b0;
         pins_o.serial_in <= tx[i];
         half();
         rx[i] = so_i.oe ? so_i.data : 1'bz;
         pins_o.sclk <= 1'b1;
         half();
      end
   endtask

   // Data line toggles once released, so no stale level lingers
   task automatic stop();
      pins_o.sclk <= idle_high;
      half();
      pins_o.select_n <= 1'b1;
      pins_o.serial_in <= ~pins_o.serial_in;
      half();
      half();
   endtask

   // pause with clock low, toggle clock and select meanwhile
   task automatic pause_gap(output logic oe_mid);
      pins_o.sclk <= 1'b0;
      half();
      pins_o.pause_n <= 1'b0;
      half();
      repeat (2) begin
         pins_o.sclk <= 1'b1;
         pins_o.select_n <= 1'b1;
         half();
         pins_o.sclk <= 1'b0;
         pins_o.select_n <= 1'b0;
         half();
      end
      oe_mid = so_i.oe;
      pins_o.pause_n <= 1'b1;
      half();
   endtask
endmodule

// >>> verification/spi_fram_read_sleep_id_test.sv
`timescale 1ns/1ps
// Self-checking bench for the serial slave
module spi_fram_read_sleep_id_test;
   import fram_spi_pkg::*;
   // Arbitrary identity and serial values
   localparam logic [7:0] CONT_V = 8'h6e;
   localparam logic [7:0] MAKER_V = 8'h2d;
   localparam logic [15:0] PROD_V = {3'h5, 5'h11, 2'h2, 3'h3, 3'h0};
   localparam logic [39:0] UNIQ_V = 40'h9a5c3e1b07;
   logic sys_clk_i;
   logic sys_rst_i;
   spi_pins_t pins;
   spi_out_t so;
   logic [7:0] mem_data = 8'h00;
   logic [ADDR_W-1:0] mem_addr;
   logic asleep;
   logic [7:0] got [16];
   int failures = 0;
   int total_checks = 0;

   spi_fram_read_sleep_id #(.CONT_BYTE(CONT_V), .MAKER_BYTE(MAKER_V), .FAMILY(PROD_V[15:13]),
      .DENSITY(PROD_V[12:8]), .SUB_CODE(PROD_V[7:6]), .REVISION(PROD_V[5:3]),
      .UNIQUE_VALUE(UNIQ_V)) spi_fram_read_sleep_id_inst (.sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i), .pins_i(pins), .mem_data_i(mem_data), .mem_addr_o(mem_addr),
      .so_o(so), .asleep_o(asleep));
   spi_host spi_host_inst (.sys_clk_i(sys_clk_i), .so_i(so), .pins_o(pins));

   ////////////////////////////////////////////////////////////////
   // Memory content follows the address so wrap and order show
   function automatic logic [7:0] pat(input logic [16:0] a);
      return 8'(a[7:0] + a[16:9]);
   endfunction
   // bitwise form of the 07h table
   function automatic logic [7:0] crc8(input logic [55:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 55; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction
   always @(posedge sys_clk_i) mem_data <= pat(mem_addr);

   // 40 MHz clock
   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end

   task automatic check(input string name, input logic [71:0] seen, input logic [71:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      if (failures == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Command, address bytes high first, then n bytes back
   task automatic run(input logic [7:0] cmd, input int nadr, input logic [31:0] adr, input int n);
      logic [7:0] rx;
      spi_host_inst.start();
      spi_host_inst.xfer(cmd, rx);
      for (int i = nadr - 1; i >= 0; i--) spi_host_inst.xfer(adr[8*i +: 8], rx);
      for (int i = 0; i < n; i++) begin
         spi_host_inst.xfer(8'ha5 ^ 8'(i), rx);
         got[i] = rx;
      end
   endtask

   ////////////////////////////////////////////////////////////////
   // read code, top address bits set and ignored
   task automatic t_read();
      run(CMD_READ, 3, 32'h00fffffe, 3);
      spi_host_inst.stop();
      check("read first", got[0], pat(17'h1fffe));
      check("read next", got[1], pat(17'h1ffff));
      check("read wrap", got[2], pat(17'h00000));
      check("read release", so.oe, 1'b0);
   endtask

   task automatic t_fast();
      spi_host_inst.idle_high = 1'b1;
      run(CMD_FAST_READ, 4, 32'h000100ff, 2);
      spi_host_inst.stop();
      check("fast first", got[0], pat(17'h00100));
      check("fast next", got[1], pat(17'h00101));
      check("fast release", so.oe, 1'b0);
      spi_host_inst.idle_high = 1'b0;
   endtask

   task automatic t_pause();
      logic oe_mid;
      logic [7:0] rx;
      run(CMD_READ, 3, 32'h00000010, 1);
      spi_host_inst.pause_gap(oe_mid);
      spi_host_inst.xfer(8'h3c, rx);
      spi_host_inst.stop();
      check("pause first", got[0], pat(17'h00010));
      check("pause float", oe_mid, 1'b0);
      check("pause resume", rx, pat(17'h00011));
   endtask

   task automatic t_ident();
      logic [71:0] v;
      v = '0;
      run(CMD_READ_IDENTITY, 0, 32'h0, 9);
      spi_host_inst.stop();
      for (int i = 0; i < 9; i++) v = {v[63:0], got[i]};
      check("identity", v, {{6{CONT_V}}, MAKER_V, PROD_V});
      check("maker part", v[71:16], {{6{CONT_V}}, MAKER_V});
      check("product part", v[15:0], PROD_V);
   endtask

   task automatic t_serial();
      logic [63:0] v;
      v = '0;
      run(CMD_SERIAL_NUMBER, 0, 32'h0, 8);
      spi_host_inst.stop();
      for (int i = 0; i < 8; i++) v = {v[55:0], got[i]};
      check("serial number", v, {16'h0000, UNIQ_V, crc8({16'h0000, UNIQ_V})});
      check("serial fields", v[47:8], UNIQ_V);
      check("customer id", v[63:48], 16'h0000);
      check("serial crc", v[7:0], crc8(v[63:8]));
   endtask

   // Sleep code with a byte after it is cancelled; with no clock after it, sleep is taken
   task automatic t_sleep();
      spi_host_inst.idle_high = 1'b1;
      // One more byte after the sleep code cancels it
      run(CMD_SLEEP, 0, 32'h0, 1);
      spi_host_inst.stop();
      check("sleep cancel", asleep, 1'b0);
      check("ignored float", got[0], 8'hzz);
      run(CMD_SLEEP, 0, 32'h0, 0);
      spi_host_inst.stop();
      check("asleep", asleep, 1'b1);
      run(CMD_READ, 3, 32'h00000abc, 1);
      spi_host_inst.stop();
      check("sleep float", got[0], 8'hzz);
      check("awake", asleep, 1'b0);
      run(CMD_READ, 3, 32'h00000abc, 1);
      spi_host_inst.stop();
      check("after wake", got[0], pat(17'h00abc));
      spi_host_inst.idle_high = 1'b0;
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge sys_clk_i);
      failures++;
      finish_test();
   end

   // Reset two cycles, settle, then scenarios
   initial begin
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
      t_read();
      t_fast();
      t_pause();
      t_ident();
      t_serial();
      t_sleep();
      finish_test();
   end
endmodule
